// >>> pkg/tlel_consts.vh
`ifndef TLEL_CONSTS_VH
`define TLEL_CONSTS_VH

// Register pointer offsets
`define TLEL_ADDR_CONFIG        4'h1
`define TLEL_ADDR_HIGH_LIMIT    4'h2
`define TLEL_ADDR_LOW_LIMIT     4'h3
`define TLEL_ADDR_CRIT_LIMIT    4'h4
`define TLEL_ADDR_AMBIENT       4'h5

// Configuration field positions
`define TLEL_CFG_HYSTERESIS_SELECT_HI        10
`define TLEL_CFG_HYSTERESIS_SELECT_LO        9
`define TLEL_CFG_POWER_DOWN     8
`define TLEL_CFG_CRIT_FREEZE    7
`define TLEL_CFG_LIMIT_FREEZE   6
`define TLEL_CFG_CLEAR          5
`define TLEL_CFG_ACTIVE_FLAG    4
`define TLEL_CFG_ALERT_ENABLE   3
`define TLEL_CFG_CRIT_ONLY      2
`define TLEL_CFG_POLARITY       1
`define TLEL_CFG_MODE           0

// Ambient status field positions
`define TLEL_AMB_OVER_CRIT      15
`define TLEL_AMB_OVER_HIGH      14
`define TLEL_AMB_UNDER_LOW      13

// Reset values and masks
`define TLEL_LIMIT_RESET        16'h0000
`define TLEL_LIMIT_MASK         16'h1FFC
`define TLEL_AMBIENT_RESET      13'h0000
`define TLEL_HYSTERESIS_SELECT_RESET         2'h0

// Hysteresis widths in ambient LSBs of 1/16 degree
`define TLEL_HYSTERESIS_SELECT_NONE          15'h0000
`define TLEL_HYSTERESIS_SELECT_1P5           15'h0018
`define TLEL_HYSTERESIS_SELECT_3P0           15'h0030
`define TLEL_HYSTERESIS_SELECT_6P0           15'h0060

// Fraction masks per resolution setting
`define TLEL_RES_MASK_9BIT      13'h1FF8
`define TLEL_RES_MASK_10BIT     13'h1FFC
`define TLEL_RES_MASK_11BIT     13'h1FFE
`define TLEL_RES_MASK_12BIT     13'h1FFF

`endif

// >>> rtl/tlel_pin_sync.v
`timescale 1ns/1ns
module tlel_pin_sync
(
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // Asynchronous pin
    input  wire        pinIn,
    // Rising edge strobe, one cycle
    output wire        riseStrobe
);

    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;
    reg level_reg;
    reg rise_reg;

    // Three-stage chain; only stage2 and stage3 are compared, stage1 only feeds stage2
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            level_reg  <= 1'b0;
            rise_reg   <= 1'b0;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // Level only moves once the last two stages agree
            if (stage2_reg == stage3_reg)
                level_reg <= stage3_reg;
            rise_reg <= (stage2_reg == stage3_reg) && stage3_reg && !level_reg;
        end
    end

    assign riseStrobe = rise_reg;

endmodule

// >>> rtl/tlel_limit_event.v
// What this block does
// R1: Writing one to critical freeze bit blocks critical limit writes until power-on reset.
// R2: Writing one to limit freeze bit blocks high and low limit writes until reset.
// R3: Clear bit in interrupt mode releases alert until new condition; reads zero.
// R4: Clear is ignored in comparator mode and while critical condition holds.
// R5: Alert active flag reads one while the alert pin is asserted.
// R6: Alert enable bit zero keeps the alert pin from ever asserting.
// R7: Either freeze bit blocks changes to enable, polarity and mode bits.
// R8: Critical-only select picks critical-only alerts; locked by limit freeze.
// R9: Polarity bit chooses asserted pin level: zero low, one high.
// R10: Mode bit chooses comparator (zero) or interrupt (one) alert behaviour.
// R11: Limits hold sign plus ten bits in 12:2; other bits unused.
// R12: Ambient value sits in bits 12:0, lowest bit one sixteenth degree.
// R13: Fraction bits below selected resolution read as zero.
// R14: Over-critical flag sets above critical, clears below critical minus hysteresis.
// R15: Over-high flag sets above high, clears at or below high minus hysteresis.
// R16: Under-low flag sets below low minus hysteresis, clears at or above low.
// R17: Two-bit hysteresis select: none, 1.5, 3.0, 6.0 degrees for all comparisons.
// R18: Power-down stops temperature updates and suppresses all alert events.
// R19: Comparator mode alert follows enabled status flags directly.
// R20: Interrupt mode alert holds while over-critical flag is set.
`timescale 1ns/1ns
`include "tlel_consts.vh"
module tlel_limit_event
(
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // Register port from the serial engine
    input  wire [3:0]  regAddr,
    input  wire        regWrite,
    input  wire [15:0] regWdata,
    output wire [15:0] regRdata,
    // Converter sample
    input  wire        sampleClk,
    input  wire [12:0] sampleData,
    input  wire [1:0]  resolutionReport,
    // Open-drain alert pin
    input  wire        alertPinIn,
    output wire        alertPinOut,
    output wire        alertPinOe
);

    // Configuration state
    reg [1:0]  hysteresisSelect_reg;
    reg        sensorPowerDown_reg;
    reg        criticalLimitFreeze_reg;
    reg        limitFreeze_reg;
    reg        alertEnable_reg;
    reg        criticalOnlySelect_reg;
    reg        alertPolarity_reg;
    reg        alertMode_reg;
    // Limits and ambient
    reg [15:0] highLimit_reg;
    reg [15:0] lowLimit_reg;
    reg [15:0] criticalLimit_reg;
    reg [12:0] ambientValue_reg;
    reg [12:0] dataStage1_reg;
    reg [12:0] dataStage2_reg;
    reg        flagUpdate_reg;
    // Status and alert
    reg        overCriticalFlag_reg;
    reg        overHighFlag_reg;
    reg        underLowFlag_reg;
    reg [2:0]  qualPrev_reg;
    reg        irqLatch_reg;
    reg        alertActiveFlag_reg;
    reg        pinOut_reg;
    reg        pinOe_reg;
    reg [15:0] rdata_reg;

    wire       sampleRise;
    wire       anyFreeze;
    wire       cfgWrite;
    wire       clearReq;
    wire [2:0] qualVec;
    wire       newEvent;
    wire       alertNext;
    wire       pinLevel;
    reg        irqLatch_next;
    reg        overCritical_next;
    reg        overHigh_next;
    reg        underLow_next;
    reg [15:0] rdata_next;
    reg [14:0] hystWidth;
    reg [14:0] ambExt;
    reg [14:0] critExt;
    reg [14:0] highExt;
    reg [14:0] lowExt;

    // Sign-extend a 13-bit reading to 15 bits so subtraction cannot wrap
    function [14:0] tlel_ext;
        input [12:0] value;
        begin
            tlel_ext = {{2{value[12]}}, value};
        end
    endfunction

    // Resolution to fraction mask
    function [12:0] tlel_res_mask;
        input [1:0] res;
        begin
            case (res)
                2'h0:    tlel_res_mask = `TLEL_RES_MASK_9BIT;
                2'h1:    tlel_res_mask = `TLEL_RES_MASK_10BIT;
                2'h2:    tlel_res_mask = `TLEL_RES_MASK_11BIT;
                default: tlel_res_mask = `TLEL_RES_MASK_12BIT;
            endcase
        end
    endfunction

    // Converter strobe arrives from another domain
    tlel_pin_sync u_sample_sync
    (
        .clock      (clock),
        .nrst       (nrst),
        .pinIn      (sampleClk),
        .riseStrobe (sampleRise)
    );

    assign anyFreeze = criticalLimitFreeze_reg | limitFreeze_reg;
    assign cfgWrite  = regWrite && (regAddr == `TLEL_ADDR_CONFIG);

    // Configuration writes with freeze protection
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            hysteresisSelect_reg    <= `TLEL_HYSTERESIS_SELECT_RESET;
            sensorPowerDown_reg     <= 1'b0;
            criticalLimitFreeze_reg <= 1'b0;
            limitFreeze_reg         <= 1'b0;
            alertEnable_reg         <= 1'b0;
            criticalOnlySelect_reg  <= 1'b0;
            alertPolarity_reg       <= 1'b0;
            alertMode_reg           <= 1'b0;
        end
        else if (cfgWrite)
        begin
            // Freeze bits are sticky; only reset clears them
            if (regWdata[`TLEL_CFG_CRIT_FREEZE])
                criticalLimitFreeze_reg <= 1'b1; // R1
            if (regWdata[`TLEL_CFG_LIMIT_FREEZE])
                limitFreeze_reg <= 1'b1; // R2
            if (!anyFreeze)
            begin
                alertEnable_reg      <= regWdata[`TLEL_CFG_ALERT_ENABLE]; // R7
                alertPolarity_reg    <= regWdata[`TLEL_CFG_POLARITY]; // R7
                alertMode_reg        <= regWdata[`TLEL_CFG_MODE]; // R7
                hysteresisSelect_reg <= regWdata[`TLEL_CFG_HYSTERESIS_SELECT_HI:`TLEL_CFG_HYSTERESIS_SELECT_LO];
            end
            if (!limitFreeze_reg)
                criticalOnlySelect_reg <= regWdata[`TLEL_CFG_CRIT_ONLY]; // R8
            // Power-down may always be cleared, but set only while unfrozen
            if (!regWdata[`TLEL_CFG_POWER_DOWN] || !anyFreeze)
                sensorPowerDown_reg <= regWdata[`TLEL_CFG_POWER_DOWN];
        end
    end

    // Limit registers; unused bits are never stored
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            highLimit_reg     <= `TLEL_LIMIT_RESET;
            lowLimit_reg      <= `TLEL_LIMIT_RESET;
            criticalLimit_reg <= `TLEL_LIMIT_RESET;
        end
        else if (regWrite)
        begin
            if (regAddr == `TLEL_ADDR_HIGH_LIMIT && !limitFreeze_reg)
                highLimit_reg <= regWdata & `TLEL_LIMIT_MASK; // R2 R11
            if (regAddr == `TLEL_ADDR_LOW_LIMIT && !limitFreeze_reg)
                lowLimit_reg <= regWdata & `TLEL_LIMIT_MASK; // R2 R11
            if (regAddr == `TLEL_ADDR_CRIT_LIMIT && !criticalLimitFreeze_reg)
                criticalLimit_reg <= regWdata & `TLEL_LIMIT_MASK; // R1 R11
        end
    end

    // Ambient capture; data pipelined so it settles while the strobe syncs
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            dataStage1_reg   <= `TLEL_AMBIENT_RESET;
            dataStage2_reg   <= `TLEL_AMBIENT_RESET;
            ambientValue_reg <= `TLEL_AMBIENT_RESET;
            flagUpdate_reg   <= 1'b0;
        end
        else
        begin
            dataStage1_reg <= sampleData;
            dataStage2_reg <= dataStage1_reg;
            flagUpdate_reg <= sampleRise && !sensorPowerDown_reg;
            if (sampleRise && !sensorPowerDown_reg) // R18
                ambientValue_reg <= dataStage2_reg & tlel_res_mask(resolutionReport); // R12 R13
        end
    end

    // Hysteresis and comparison thresholds
    always @*
    begin
        case (hysteresisSelect_reg) // R17
            2'h0:    hystWidth = `TLEL_HYSTERESIS_SELECT_NONE;
            2'h1:    hystWidth = `TLEL_HYSTERESIS_SELECT_1P5;
            2'h2:    hystWidth = `TLEL_HYSTERESIS_SELECT_3P0;
            default: hystWidth = `TLEL_HYSTERESIS_SELECT_6P0;
        endcase
        ambExt  = tlel_ext(ambientValue_reg);
        critExt = tlel_ext(criticalLimit_reg[12:0]);
        highExt = tlel_ext(highLimit_reg[12:0]);
        lowExt  = tlel_ext(lowLimit_reg[12:0]);
    end

    // Status flags with hysteresis; between thresholds a flag holds
    always @*
    begin
        overCritical_next = overCriticalFlag_reg;
        overHigh_next     = overHighFlag_reg;
        underLow_next     = underLowFlag_reg;
        if ($signed(ambExt) > $signed(critExt))
            overCritical_next = 1'b1; // R14
        else if ($signed(ambExt) < $signed(critExt - hystWidth))
            overCritical_next = 1'b0; // R14
        if ($signed(ambExt) > $signed(highExt))
            overHigh_next = 1'b1; // R15
        else if ($signed(ambExt) <= $signed(highExt - hystWidth))
            overHigh_next = 1'b0; // R15
        if ($signed(ambExt) < $signed(lowExt - hystWidth))
            underLow_next = 1'b1; // R16
        else if ($signed(ambExt) >= $signed(lowExt))
            underLow_next = 1'b0; // R16
    end

    // Flags only move after a fresh reading
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            overCriticalFlag_reg <= 1'b0;
            overHighFlag_reg     <= 1'b0;
            underLowFlag_reg     <= 1'b0;
        end
        else if (flagUpdate_reg)
        begin
            overCriticalFlag_reg <= overCritical_next;
            overHighFlag_reg     <= overHigh_next;
            underLowFlag_reg     <= underLow_next;
        end
    end

    // Conditions that may raise the alert
    assign qualVec = {overCriticalFlag_reg,
                      overHighFlag_reg & !criticalOnlySelect_reg,
                      underLowFlag_reg & !criticalOnlySelect_reg}; // R8
    assign newEvent = (|(qualVec & ~qualPrev_reg)) && alertEnable_reg && alertMode_reg && !sensorPowerDown_reg;
    // Clear is a write-only strobe, ignored in comparator mode or over critical
    assign clearReq = cfgWrite && regWdata[`TLEL_CFG_CLEAR] && alertMode_reg && !overCriticalFlag_reg; // R3 R4

    // Interrupt latch; a new event in the clear cycle wins
    always @*
    begin
        irqLatch_next = irqLatch_reg;
        if (newEvent)
            irqLatch_next = 1'b1;
        else if (clearReq || !alertMode_reg || !alertEnable_reg || sensorPowerDown_reg)
            irqLatch_next = 1'b0; // R3
    end

    // Alert decision per mode
    assign alertNext = alertEnable_reg && !sensorPowerDown_reg && // R6 R18
                       (alertMode_reg ? (irqLatch_next | overCriticalFlag_reg) : (|qualVec)); // R10 R19 R20
    assign pinLevel  = alertNext ? alertPolarity_reg : !alertPolarity_reg; // R9

    // Alert state and pin; open drain drives only for a low level
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            qualPrev_reg        <= 3'h0;
            irqLatch_reg        <= 1'b0;
            alertActiveFlag_reg <= 1'b0;
            pinOut_reg          <= 1'b0;
            pinOe_reg           <= 1'b0;
        end
        else
        begin
            qualPrev_reg        <= qualVec;
            irqLatch_reg        <= irqLatch_next;
            alertActiveFlag_reg <= alertNext; // R5
            pinOut_reg          <= 1'b0;
            pinOe_reg           <= !pinLevel;
        end
    end

    // Read data mux; unmapped pointers read zero
    always @*
    begin
        rdata_next = 16'h0000;
        case (regAddr)
            `TLEL_ADDR_CONFIG:
                rdata_next = {5'h00, hysteresisSelect_reg, sensorPowerDown_reg,
                              criticalLimitFreeze_reg, limitFreeze_reg, 1'b0, // R3
                              alertActiveFlag_reg, alertEnable_reg, criticalOnlySelect_reg, // R5
                              alertPolarity_reg, alertMode_reg};
            `TLEL_ADDR_HIGH_LIMIT: rdata_next = highLimit_reg;
            `TLEL_ADDR_LOW_LIMIT:  rdata_next = lowLimit_reg;
            `TLEL_ADDR_CRIT_LIMIT: rdata_next = criticalLimit_reg;
            `TLEL_ADDR_AMBIENT:
                rdata_next = {overCriticalFlag_reg, overHighFlag_reg, underLowFlag_reg, ambientValue_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // Registered read data, one cycle behind the pointer
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata_reg <= 16'h0000;
        else
            rdata_reg <= rdata_next;
    end

    assign regRdata    = rdata_reg;
    assign alertPinOut = pinOut_reg;
    assign alertPinOe  = pinOe_reg;

endmodule

// >>> tb/tlel_limit_event_props.sv
`timescale 1ns/1ns
module tlel_limit_event_props
(
    // Clock and reset
    input wire        clock,
    input wire        nrst,
    // Register port
    input wire [3:0]  regAddr,
    input wire        regWrite,
    input wire [15:0] regWdata,
    input wire [15:0] regRdata,
    // Alert pin
    input wire        alertPinOut,
    input wire        alertPinOe
);
    reg critLock_reg;
    reg limitLock_reg;
    reg critOld_reg;
    reg limitOld_reg;

    // Shadow freeze bits, delayed a cycle so the locking write itself passes
    always @(posedge clock or negedge nrst)
        if (!nrst)
        begin
            critLock_reg  <= 1'b0;
            limitLock_reg <= 1'b0;
            critOld_reg   <= 1'b0;
            limitOld_reg  <= 1'b0;
        end
        else
        begin
            critLock_reg  <= critLock_reg | (regWrite && regAddr == 4'h1 && regWdata[7]);
            limitLock_reg <= limitLock_reg | (regWrite && regAddr == 4'h1 && regWdata[6]);
            critOld_reg   <= critLock_reg;
            limitOld_reg  <= limitLock_reg;
        end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Config pointer held over two edges
    sequence cfgSteady;
        $past(regAddr) == 4'h1 && $past(regAddr, 2) == 4'h1;
    endsequence
    // Same, with no write in the last three edges
    sequence cfgQuiet;
        cfgSteady ##0 !$past(regWrite) && !$past(regWrite, 2) && !$past(regWrite, 3);
    endsequence

    a_clear_reads_zero: assert property ($past(regAddr) == 4'h1 |-> regRdata[5] == 1'b0)
        else $error("clear bit read back as one");
    a_status_is_pin: assert property (cfgQuiet |-> regRdata[4] == ($past(alertPinOe) ^ regRdata[1]))
        else $error("status flag disagrees with pin");
    a_enable_gates_pin: assert property (cfgQuiet ##0 !regRdata[3] |-> !regRdata[4])
        else $error("alert asserted while disabled");
    a_down_is_quiet: assert property (cfgQuiet ##0 regRdata[8] |-> !regRdata[4])
        else $error("alert asserted in power-down");
    a_limit_unused_zero: assert property ($past(regAddr) inside {4'h2, 4'h3, 4'h4} |-> (regRdata & 16'hE003) == 16'h0000)
        else $error("unused limit bits set");
    a_crit_frozen: assert property (critOld_reg && $past(regAddr) == 4'h4 && $past(regAddr, 2) == 4'h4 |-> $stable(regRdata))
        else $error("critical limit changed while frozen");
    a_limits_frozen: assert property (limitOld_reg && $past(regAddr) inside {4'h2, 4'h3} && $stable(regAddr) |=> $stable(regRdata))
        else $error("high or low limit changed while frozen");
    // Freeze must predate the write two edges back, so the locking write itself may still set control bits
    a_ctrl_frozen: assert property ($past(critOld_reg || limitOld_reg) ##0 cfgSteady |->
        $stable(regRdata[3]) && $stable(regRdata[1:0]) && $stable(regRdata[10:9]))
        else $error("alert control bits changed while frozen");
    // Open drain: the pin is only ever pulled low
    a_drain_only_low: assert property (alertPinOut == 1'b0)
        else $error("alert pin driven high");
    a_lock_sticky: assert property (cfgSteady |-> (regRdata[7] || !critOld_reg) && (regRdata[6] || !limitOld_reg))
        else $error("freeze bit dropped without reset");
endmodule

bind tlel_limit_event tlel_limit_event_props tlel_limit_event_props_inst
(
    .clock(clock),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .alertPinOut(alertPinOut),
    .alertPinOe(alertPinOe)
);

// >>> tb/tlel_conv_model.sv
`timescale 1ns/1ns
module tlel_conv_model
(
    // Clock
    input  wire        clock,
    // Sample link toward the block
    output reg         sampleClk,
    output reg  [12:0] sampleData
);
    // Link clock stands still between frames
    initial
    begin
        sampleClk = 1'b0;
        sampleData = 13'h0000;
    end

    // One frame: data two cycles early, one 80 ns link period, then release
    task automatic send(input logic [12:0] v);
        sampleData = v;
        repeat (2) @(posedge clock);
        #1;
        sampleClk = 1'b1;
        #40;
        sampleClk = 1'b0;
        #40;
        sampleData = ~v; // Stale data must not look valid
    endtask
endmodule

// >>> tb/tlel_limit_event_tb_top.sv
`timescale 1ns/1ns
module tlel_limit_event_tb_top;
    typedef struct {bit p; logic [15:0] e; logic [15:0] m;} tlel_note_t;
    localparam ALL = 16'hFFFF;
    // Bench signals
    reg          clock = 1'b0;
    reg          nrst = 1'b0;
    reg  [3:0]   regAddr = 4'h0;
    reg          regWrite = 1'b0;
    reg  [15:0]  regWdata = 16'h0000;
    reg  [1:0]   resolutionReport = 2'h3;
    reg          tick = 1'b0;
    wire [15:0]  regRdata;
    wire         sampleClk;
    wire [12:0]  sampleData;
    wire         alertPinOe;
    wire         pinLevel = !alertPinOe; // Pull-up on the open-drain pin
    integer      num_errors = 0;
    integer      samples_checked = 0;
    integer      seed = 47169;
    integer      cycles = 0;
    integer      i;
    integer      h;
    reg  [31:0]  rv;
    tlel_note_t  nt;
    tlel_note_t  noteQ[$];

    // Design and converter model
    tlel_limit_event tlel_limit_event_inst (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .sampleClk(sampleClk), .sampleData(sampleData),
        .resolutionReport(resolutionReport), .alertPinIn(pinLevel), .alertPinOut(), .alertPinOe(alertPinOe));
    tlel_conv_model tlel_conv_model_inst (.clock(clock), .sampleClk(sampleClk), .sampleData(sampleData));

    // Clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim;
        end
    end

    // Oldest note is judged when the driver flags a result as due
    always @(posedge clock)
        if (tick)
        begin
            nt = noteQ.pop_front();
            check_word(nt.p ? "pin" : "rdata", nt.e & nt.m, (nt.p ? {15'h0000, pinLevel} : regRdata) & nt.m);
        end

    task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic step;
        @(posedge clock);
        #1;
    endtask

    task automatic note(input bit p, input logic [15:0] e, input logic [15:0] m);
        noteQ.push_back('{p, e, m});
        tick = 1'b1;
        step;
        tick = 1'b0;
    endtask

    // Write leaves strobe low for an edge so writes never merge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        step;
        regWrite = 1'b0;
        step;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        regAddr = a;
        step;
        note(1'b0, e, m);
    endtask

    task automatic pn(input logic lvl);
        note(1'b1, {15'h0000, lvl}, 16'h0001);
    endtask

    task automatic smp(input logic [12:0] v);
        tlel_conv_model_inst.send(v);
    endtask

    task end_sim;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20) step;
        nrst = 1'b1;
        step;
        // Reset values, unmapped pointers included
        for (i = 0; i < 8; i++)
            rd(i[3:0], 16'h0000, ALL);
        // Random limit writes keep only sign and ten bits
        for (i = 0; i < 4; i++)
        begin
            rv = $random(seed);
            wr(4'h2 + i[3:0] % 3, rv[15:0]);
            rd(4'h2 + i[3:0] % 3, rv[15:0] & 16'h1FFC, ALL);
        end
        wr(4'h2, 16'h0500);
        wr(4'h3, 16'h0100);
        wr(4'h4, 16'h0600);
        // Every resolution masks its unused fraction bits
        for (i = 0; i < 4; i++)
        begin
            resolutionReport = i[1:0];
            smp(13'h0ABF);
            rd(4'h5, 16'h0ABF & (16'h1FFF << (3 - i)), 16'h1FFF);
        end
        // Each hysteresis width on the high flag, comparator pin
        for (i = 0; i < 4; i++)
        begin
            h = (i == 0) ? 0 : (12 << i);
            wr(4'h1, 16'h0008 | (i[15:0] << 9));
            smp(13'h0501);
            rd(4'h5, 16'h4501, ALL);
            pn(1'b0);
            smp(13'h0501 - h[12:0]);
            rd(4'h5, 16'h4000, 16'h4000);
            smp(13'h0500 - h[12:0]);
            rd(4'h5, 16'h0000, 16'hE000);
            pn(1'b1);
        end
        // Critical flag hysteresis with critical-only alerts
        wr(4'h1, 16'h020C);
        smp(13'h0601);
        rd(4'h5, 16'hC601, ALL);
        pn(1'b0);
        smp(13'h05E8);
        rd(4'h5, 16'h8000, 16'h8000);
        smp(13'h05E7);
        rd(4'h5, 16'h45E7, ALL);
        pn(1'b1);
        // Low flag, and clear ignored in comparator mode
        wr(4'h1, 16'h0208);
        smp(13'h00E8);
        rd(4'h5, 16'h00E8, ALL);
        smp(13'h00E7);
        rd(4'h5, 16'h20E7, ALL);
        wr(4'h1, 16'h0228);
        pn(1'b0);
        rd(4'h1, 16'h0218, ALL);
        smp(13'h00FF);
        rd(4'h5, 16'h2000, 16'h2000);
        smp(13'h0100);
        rd(4'h5, 16'h0100, ALL);
        // Enable gate and polarity
        smp(13'h0501);
        wr(4'h1, 16'h0200);
        pn(1'b1);
        rd(4'h1, 16'h0200, ALL);
        wr(4'h1, 16'h020A);
        pn(1'b1);
        rd(4'h1, 16'h021A, ALL);
        smp(13'h0400);
        pn(1'b0);
        // Interrupt mode latch, clear, and critical hold
        wr(4'h1, 16'h0009);
        smp(13'h0501);
        pn(1'b0);
        smp(13'h0400);
        pn(1'b0);
        wr(4'h1, 16'h0029);
        pn(1'b1);
        smp(13'h0601);
        wr(4'h1, 16'h0029);
        pn(1'b0);
        rd(4'h1, 16'h0019, ALL);
        // Power-down silences the pin and refuses samples
        wr(4'h1, 16'h0108);
        pn(1'b1);
        smp(13'h0400);
        rd(4'h5, 16'hC601, ALL);
        // Freeze bits
        wr(4'h1, 16'h0088);
        wr(4'h4, 16'h0700);
        rd(4'h4, 16'h0600, ALL);
        wr(4'h1, 16'h0007);
        rd(4'h1, 16'h008C, 16'hFFEF);
        wr(4'h2, 16'h0480);
        rd(4'h2, 16'h0480, ALL);
        wr(4'h1, 16'h0044);
        rd(4'h1, 16'h00CC, 16'hFFEF);
        wr(4'h3, 16'h0200);
        rd(4'h3, 16'h0100, ALL);
        wr(4'h1, 16'h0000);
        rd(4'h1, 16'h00CC, 16'hFFEF);
        // Only a reset lifts the freeze
        nrst = 1'b0;
        repeat (2) step;
        nrst = 1'b1;
        step;
        rd(4'h1, 16'h0000, ALL);
        end_sim;
    end
endmodule
